// [include/rss_pkg.sv]
package rss_pkg;

  // ************************************************************
  // register map, word index; byte address is four times index
  // ************************************************************
  localparam logic [2:0] ADDR_STATUS = 3'h0;
  localparam logic [2:0] ADDR_POWER_CONTROL_REG = 3'h1;
  localparam logic [2:0] ADDR_CTRL = 3'h2;
  localparam logic [2:0] ADDR_PIN = 3'h3;

  localparam int STAT_TO_BIT = 4;
  localparam int STAT_PD_BIT = 3;
  localparam int CTRL_PULLUP_BIT = 0;
  localparam int PIN_LEVEL_BIT = 0;
  localparam int PIN_FUNC_BIT = 1;
  localparam int PIN_HOLD_BIT = 2;
  localparam int PIN_RUN_BIT = 3;
  localparam logic [31:0] POWER_CONTROL_REG_WR_MASK = 32'h0000_00CF;

  // ************************************************************
  // program counter
  // ************************************************************
  localparam int PC_W = 15;
  localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
  localparam logic [PC_W-1:0] PC_VECTOR = 15'h0004;
  localparam logic [PC_W-1:0] PC_STEP = 15'h0001;

  // ************************************************************
  // timing at 125 MHz
  // ************************************************************
  localparam int CLK_MHZ = 125;
  localparam int POWERUP_TIMER_MS = 64;
  localparam int POWERUP_TIMER_CYCLES_DEF = POWERUP_TIMER_MS * 1000 * CLK_MHZ;
  localparam int POWERUP_TIMER_W = 23;
  localparam int FILT_NS = 200;
  localparam int FILT_CYCLES = (FILT_NS * CLK_MHZ + 999) / 1000;
  localparam logic [4:0] FILT_LAST = 5'(FILT_CYCLES - 1);

  // ************************************************************
  // reset cause flags, power_control_reg bits 7,6,3..0 then status to/pd
  // ************************************************************
  typedef struct packed {
    logic stack_over;
    logic stack_under;
    logic ext_reset;
    logic reset_instr;
    logic power_on;
    logic brown_out;
    logic watchdog_expired;
    logic powerdown;
  } rss_flags_type;

  // brown_out is unknown after power-on; it is chosen as 1
  localparam rss_flags_type FLAGS_POR = rss_flags_type'(8'h37);

  typedef enum logic [1:0] {
    ST_POWER,
    ST_POWERUP_TIMER,
    ST_START,
    ST_RUN
  } rss_state_type;

endpackage

// [hw/rss_top.sv]
`timescale 1ns/10ps
module rss_top #(
  parameter int unsigned POWERUP_TIMER_CYCLES = rss_pkg::POWERUP_TIMER_CYCLES_DEF
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic ext_reset_pin_i,
  output logic ext_reset_pin_o,
  output logic ext_reset_pin_oe_o,
  output logic pullup_en_o,
  input wire logic ext_reset_pin_enable_i,
  input wire logic low_voltage_program_enable_i,
  input wire logic stack_fault_reset_enable_i,
  input wire logic powerup_timer_enable_n_i,
  input wire logic power_on_active_i,
  input wire logic brown_out_active_i,
  input wire logic prog_mode_exit_i,
  input wire logic osc_start_required_i,
  input wire logic osc_start_done_i,
  input wire logic watchdog_expire_i,
  input wire logic watchdog_clear_op_i,
  input wire logic sleep_enter_i,
  input wire logic interrupt_wake_i,
  input wire logic global_interrupt_enable_i,
  input wire logic reset_instr_i,
  input wire logic stack_overflow_i,
  input wire logic stack_underflow_i,
  input wire logic [rss_pkg::PC_W-1:0] pc_i,
  output logic core_reset_o,
  output logic sleeping_o,
  output logic pc_load_o,
  output logic [rss_pkg::PC_W-1:0] pc_value_o,
  output logic push_return_o,
  output rss_pkg::rss_flags_type flags_o,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  // ************************************************************
  // synchronisers for pin and analog detector levels
  // ************************************************************
  logic [2:0] async_m_q;
  logic [2:0] async_s_q;
  logic pin_s;
  logic por_s;
  logic bor_s;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      // detectors start active so no timer runs before their levels arrive
      async_m_q <= 3'h7;
      async_s_q <= 3'h7;
    end else begin
      async_m_q <= {brown_out_active_i, power_on_active_i, ext_reset_pin_i};
      async_s_q <= async_m_q;
    end
  end

  assign pin_s = async_s_q[0];
  assign por_s = async_s_q[1];
  assign bor_s = async_s_q[2];

  // ************************************************************
  // pin glitch filter
  // ************************************************************
  // the filter adds FILT_CYCLES of latency to every real edge too
  logic [4:0] filt_cnt_q;
  logic pin_filt_q;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      filt_cnt_q <= 5'h00;
      pin_filt_q <= 1'b1;
    end else if (pin_s == pin_filt_q) begin
      filt_cnt_q <= 5'h00;
    end else if (filt_cnt_q == rss_pkg::FILT_LAST) begin
      filt_cnt_q <= 5'h00;
      pin_filt_q <= pin_s;
    end else begin
      filt_cnt_q <= filt_cnt_q + 5'h01;
    end
  end

  logic pin_fn_en;
  logic pin_hold;
  logic osc_ok;

  assign pin_fn_en = ext_reset_pin_enable_i | low_voltage_program_enable_i;
  assign pin_hold = pin_fn_en & ~pin_filt_q;
  assign osc_ok = ~osc_start_required_i | osc_start_done_i;
  assign ext_reset_pin_o = 1'b0;
  assign ext_reset_pin_oe_o = 1'b0;

  // ************************************************************
  // reset causes in priority order
  // ************************************************************
  rss_pkg::rss_state_type state_q;
  logic sleep_q;
  logic running;
  logic evt_pwr;
  logic evt_pin;
  logic evt_wdt;
  logic evt_wwake;
  logic evt_ovf;
  logic evt_unf;
  logic evt_ri;
  logic evt_iwake;
  logic evt_rst;

  assign running = state_q == rss_pkg::ST_RUN;
  assign evt_pwr = por_s | bor_s | prog_mode_exit_i;
  assign evt_pin = ~evt_pwr & running & pin_hold;
  assign evt_wdt = ~evt_pwr & ~evt_pin & running & ~sleep_q
                   & watchdog_expire_i;
  assign evt_wwake = ~evt_pwr & ~evt_pin & running & sleep_q
                     & watchdog_expire_i;
  assign evt_ovf = ~evt_pwr & ~evt_pin & ~evt_wdt & ~evt_wwake & running
                   & stack_fault_reset_enable_i & stack_overflow_i;
  assign evt_unf = ~evt_pwr & ~evt_pin & ~evt_wdt & ~evt_wwake & running
                   & stack_fault_reset_enable_i & stack_underflow_i;
  assign evt_ri = ~evt_pwr & ~evt_pin & ~evt_wdt & ~evt_wwake & running
                  & ~evt_ovf & ~evt_unf & reset_instr_i;
  assign evt_iwake = ~evt_pwr & ~evt_pin & ~evt_wdt & ~evt_wwake & running
                     & sleep_q & interrupt_wake_i;
  assign evt_rst = evt_pin | evt_wdt | evt_ovf | evt_unf | evt_ri;

  // ************************************************************
  // start-up sequencer
  // ************************************************************
  logic [rss_pkg::POWERUP_TIMER_W-1:0] powerup_timer_cnt_q;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= rss_pkg::ST_POWER;
      powerup_timer_cnt_q <= '0;
    end else if (evt_pwr) begin
      state_q <= rss_pkg::ST_POWER;
    end else if (evt_rst) begin
      state_q <= rss_pkg::ST_START;
    end else begin
      case (state_q)
        rss_pkg::ST_POWER: begin
          // timer only starts once both detectors have let go
          if (!powerup_timer_enable_n_i) begin
            state_q <= rss_pkg::ST_POWERUP_TIMER;
            powerup_timer_cnt_q <= rss_pkg::POWERUP_TIMER_W'(POWERUP_TIMER_CYCLES - 1);
          end else begin
            state_q <= rss_pkg::ST_START;
          end
        end
        rss_pkg::ST_POWERUP_TIMER: begin
          // pin level is not looked at, so the timer runs under it
          if (powerup_timer_cnt_q == '0) begin
            state_q <= rss_pkg::ST_START;
          end else begin
            powerup_timer_cnt_q <= powerup_timer_cnt_q - 1'b1;
          end
        end
        rss_pkg::ST_START: begin
          if (osc_ok && !pin_hold) begin
            state_q <= rss_pkg::ST_RUN;
          end
        end
        rss_pkg::ST_RUN: begin
          state_q <= rss_pkg::ST_RUN;
        end
        default: begin
          state_q <= rss_pkg::ST_POWER;
        end
      endcase
    end
  end

  assign core_reset_o = ~running;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sleep_q <= 1'b0;
    end else if (evt_pwr || evt_rst || evt_wwake || evt_iwake) begin
      sleep_q <= 1'b0;
    end else if (running && sleep_enter_i) begin
      sleep_q <= 1'b1;
    end
  end

  assign sleeping_o = sleep_q;

  // ************************************************************
  // program counter loads
  // ************************************************************
  logic vec_pend_q;
  logic pc_load_q;
  logic push_q;
  logic [rss_pkg::PC_W-1:0] pc_value_q;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vec_pend_q <= 1'b0;
      pc_load_q <= 1'b0;
      push_q <= 1'b0;
      pc_value_q <= rss_pkg::PC_RESET;
    end else begin
      vec_pend_q <= evt_iwake & global_interrupt_enable_i;
      push_q <= vec_pend_q & ~evt_pwr & ~evt_rst;
      pc_load_q <= evt_pwr | evt_rst | evt_wwake | evt_iwake | vec_pend_q;
      if (evt_pwr || evt_rst) begin
        pc_value_q <= rss_pkg::PC_RESET;
      end else if (evt_wwake || evt_iwake) begin
        pc_value_q <= pc_i + rss_pkg::PC_STEP;
      end else if (vec_pend_q) begin
        pc_value_q <= rss_pkg::PC_VECTOR;
      end
    end
  end

  assign pc_load_o = pc_load_q;
  assign pc_value_o = pc_value_q;
  assign push_return_o = push_q;

  // ************************************************************
  // avalon slave, one wait cycle on every access
  // ************************************************************
  logic ack_q;
  logic req;
  logic acc_wr;
  logic [31:0] rdata_q;
  logic pullup_sw_q;
  logic pullup_q;
  rss_pkg::rss_flags_type flags_q;

  assign req = avs_read | avs_write;
  assign acc_wr = avs_write & ack_q;
  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata = rdata_q;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= req & ~ack_q;
      if (avs_read && !ack_q) begin
        rdata_q <= 32'h0000_0000;
        case (avs_address)
          rss_pkg::ADDR_STATUS: begin
            rdata_q[rss_pkg::STAT_TO_BIT] <= flags_q.watchdog_expired;
            rdata_q[rss_pkg::STAT_PD_BIT] <= flags_q.powerdown;
          end
          rss_pkg::ADDR_POWER_CONTROL_REG: begin
            rdata_q <= {24'h00_0000, flags_q[7:6], 2'h0, flags_q[5:2]};
          end
          rss_pkg::ADDR_CTRL: begin
            rdata_q[rss_pkg::CTRL_PULLUP_BIT] <= pullup_sw_q;
          end
          rss_pkg::ADDR_PIN: begin
            rdata_q[rss_pkg::PIN_LEVEL_BIT] <= pin_s;
            rdata_q[rss_pkg::PIN_FUNC_BIT] <= pin_fn_en;
            rdata_q[rss_pkg::PIN_HOLD_BIT] <= pin_hold;
            rdata_q[rss_pkg::PIN_RUN_BIT] <= running;
          end
          default: begin
            rdata_q <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pullup_sw_q <= 1'b0;
      pullup_q <= 1'b1;
    end else begin
      if (acc_wr && avs_address == rss_pkg::ADDR_CTRL) begin
        pullup_sw_q <= avs_writedata[rss_pkg::CTRL_PULLUP_BIT];
      end
      pullup_q <= pin_fn_en | pullup_sw_q;
    end
  end

  assign pullup_en_o = pullup_q;

  // ************************************************************
  // reset cause flags
  // ************************************************************
  // later assignments win, so a hardware event beats a software write
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flags_q <= rss_pkg::FLAGS_POR;
    end else begin
      if (acc_wr && avs_address == rss_pkg::ADDR_POWER_CONTROL_REG) begin
        flags_q.stack_over <= avs_writedata[7];
        flags_q.stack_under <= avs_writedata[6];
        flags_q.ext_reset <= avs_writedata[3];
        flags_q.reset_instr <= avs_writedata[2];
        flags_q.power_on <= avs_writedata[1];
        flags_q.brown_out <= avs_writedata[0];
      end
      if (watchdog_clear_op_i && running) begin
        flags_q.watchdog_expired <= 1'b1;
        flags_q.powerdown <= 1'b1;
      end
      if (sleep_enter_i && running) begin
        flags_q.watchdog_expired <= 1'b1;
        flags_q.powerdown <= 1'b0;
      end
      if (por_s || prog_mode_exit_i) begin
        flags_q <= rss_pkg::FLAGS_POR;
      end else if (bor_s) begin
        flags_q.stack_over <= 1'b0;
        flags_q.stack_under <= 1'b0;
        flags_q.ext_reset <= 1'b1;
        flags_q.reset_instr <= 1'b1;
        flags_q.brown_out <= 1'b0;
        flags_q.watchdog_expired <= 1'b1;
        flags_q.powerdown <= 1'b1;
      end else if (evt_pin) begin
        flags_q.ext_reset <= 1'b0;
        if (sleep_q) begin
          flags_q.watchdog_expired <= 1'b1;
          flags_q.powerdown <= 1'b0;
        end
      end else if (evt_wdt) begin
        flags_q.watchdog_expired <= 1'b0;
      end else if (evt_wwake) begin
        flags_q.watchdog_expired <= 1'b0;
        flags_q.powerdown <= 1'b0;
      end else if (evt_ovf) begin
        flags_q.stack_over <= 1'b1;
      end else if (evt_unf) begin
        flags_q.stack_under <= 1'b1;
      end else if (evt_ri) begin
        flags_q.reset_instr <= 1'b0;
      end else if (evt_iwake) begin
        flags_q.watchdog_expired <= 1'b1;
        flags_q.powerdown <= 1'b0;
      end
    end
  end

  assign flags_o = flags_q;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);

  logic [rss_pkg::POWERUP_TIMER_W:0] powerup_timer_len_q;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      powerup_timer_len_q <= '0;
    end else if (state_q == rss_pkg::ST_POWERUP_TIMER) begin
      powerup_timer_len_q <= powerup_timer_len_q + 1'b1;
    end else begin
      powerup_timer_len_q <= '0;
    end
  end

  pin_off_a: assert property (
    running && !pin_fn_en && !evt_pwr && !evt_rst |=> running)
    else $error("disabled pin function caused a reset");

  pin_hold_a: assert property (
    pin_hold && !evt_pwr |=> !running)
    else $error("core left reset while pin held low");

  glitch_filt_a: assert property (
    $changed(pin_filt_q) |-> $past(filt_cnt_q) == rss_pkg::FILT_LAST)
    else $error("filtered pin changed before the filter time");

  no_drive_a: assert property (
    !ext_reset_pin_oe_o)
    else $error("reset pin driven");

  pullup_sw_a: assert property (
    !pin_fn_en && $stable(pin_fn_en) |=> pullup_en_o == $past(pullup_sw_q))
    else $error("pull-up not under software control");

  wdt_reset_a: assert property (
    evt_wdt |=> !flags_q.watchdog_expired && pc_load_o
                && pc_value_o == rss_pkg::PC_RESET && !running)
    else $error("watchdog reset wrong");

  ri_reset_a: assert property (
    evt_ri |=> !flags_q.reset_instr && pc_load_o && !running
               && pc_value_o == rss_pkg::PC_RESET)
    else $error("reset instruction handling wrong");

  stack_flag_a: assert property (
    evt_ovf |=> flags_q.stack_over && !running)
    else $error("stack overflow flag not set");

  powerup_timer_len_a: assert property (
    state_q == rss_pkg::ST_POWERUP_TIMER ##1 state_q == rss_pkg::ST_START
    |-> $past(powerup_timer_len_q) == (rss_pkg::POWERUP_TIMER_W + 1)'(POWERUP_TIMER_CYCLES - 1))
    else $error("power-up timer length wrong");

  start_gate_a: assert property (
    $rose(running) |-> $past(osc_ok && !pin_hold))
    else $error("started before release conditions");

  por_flags_a: assert property (
    por_s |=> flags_q == rss_pkg::FLAGS_POR && !running)
    else $error("power-on flags wrong");

  bor_flags_a: assert property (
    bor_s && !por_s && !prog_mode_exit_i |=> !flags_q.brown_out
    && flags_q.power_on == $past(flags_q.power_on))
    else $error("brown-out flags wrong");

  int_vec_a: assert property (
    evt_iwake && global_interrupt_enable_i ##1 !evt_rst && !evt_pwr
    |=> pc_load_o && pc_value_o == rss_pkg::PC_VECTOR && push_return_o)
    else $error("interrupt vector not taken");

  status_zero_a: assert property (
    avs_read && ack_q && avs_address == rss_pkg::ADDR_STATUS
    |-> avs_readdata[2:0] == 3'h0 && avs_readdata[31:5] == '0)
    else $error("unimplemented status bits not zero");

  flags_hold_a: assert property (
    !evt_pwr && !evt_rst && !evt_wwake && !evt_iwake && !acc_wr
    && !watchdog_clear_op_i && !sleep_enter_i |=> $stable(flags_q))
    else $error("flags changed without cause");

  powerup_timer_run_c: cover property (
    state_q == rss_pkg::ST_POWERUP_TIMER ##1 state_q == rss_pkg::ST_START);
  pin_rst_c: cover property (evt_pin ##[1:100] running);
  wake_c: cover property (evt_iwake && global_interrupt_enable_i);
  wdt_c: cover property (evt_wwake);

endmodule

// [verification/rss_pin_model.sv]
`timescale 1ns/10ps
module rss_pin_model (
  input wire logic clock_i,
  input wire logic hold_low_i,
  input wire logic pullup_en_i,
  input wire logic dut_drive_i,
  input wire logic dut_oe_i,
  output logic pin_o
);
  logic last_q;

  // ********
  // pin wire
  // ********
  always_ff @(posedge clock_i) begin
    last_q <= pin_o;
  end

  // an undriven pin without pull-up wanders, so it toggles every cycle
  always_comb begin
    if (dut_oe_i) begin
      pin_o = dut_drive_i;
    end else if (hold_low_i) begin
      pin_o = 1'b0;
    end else if (pullup_en_i) begin
      pin_o = 1'b1;
    end else begin
      pin_o = ~last_q;
    end
  end
endmodule

// [verification/rss_top_tb_top.sv]
`timescale 1ns/10ps
module rss_top_tb_top;
  logic clock_i, rst_b_i, hold, pin, pin_en, low_voltage_program_enable, stk_en, powerup_timer_n;
  logic por, bor, prog, osc, wclr, slp, iwake, wexp, ovf, unf, rins;
  logic avs_read, avs_write, avs_waitrequest, oe, drv, pull;
  logic core, sleeping, load, push, global_interrupt_enable, oreq;
  logic [2:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [rss_pkg::PC_W-1:0] pcv;
  rss_pkg::rss_flags_type flags;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  logic [3:0] ev [5] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h4};
  logic [7:0] fl [5] = '{8'h31, 8'hB3, 8'h73, 8'h23, 8'h33};

  rss_top #(.POWERUP_TIMER_CYCLES(20)) dut (
    .clock_i, .rst_b_i, .ext_reset_pin_i(pin), .ext_reset_pin_o(drv),
    .ext_reset_pin_oe_o(oe), .pullup_en_o(pull),
    .ext_reset_pin_enable_i(pin_en), .low_voltage_program_enable_i(low_voltage_program_enable),
    .stack_fault_reset_enable_i(stk_en), .powerup_timer_enable_n_i(powerup_timer_n),
    .power_on_active_i(por), .brown_out_active_i(bor),
    .prog_mode_exit_i(prog), .osc_start_required_i(oreq),
    .osc_start_done_i(osc), .watchdog_expire_i(wexp),
    .watchdog_clear_op_i(wclr), .sleep_enter_i(slp),
    .interrupt_wake_i(iwake), .global_interrupt_enable_i(global_interrupt_enable),
    .reset_instr_i(rins), .stack_overflow_i(ovf),
    .stack_underflow_i(unf), .pc_i(15'h0100), .core_reset_o(core),
    .sleeping_o(sleeping), .pc_load_o(load), .pc_value_o(pcv),
    .push_return_o(push), .flags_o(flags), .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);

  rss_pin_model pm (.clock_i, .hold_low_i(hold), .pullup_en_i(pull),
    .dut_drive_i(drv), .dut_oe_i(oe), .pin_o(pin));

  // ********
  // helpers
  // ********
  task automatic conclude();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge clock_i);
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [2:0] a,
                     input logic [31:0] d);
    @(posedge clock_i);
    avs_address <= a;
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= d;
    do begin
      @(posedge clock_i);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rdchk(input logic [2:0] a, input logic [31:0] exp,
                       input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask

  task automatic wait_run(input int lim);
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (core !== 1'b0 && n < lim);
    chk("core_reset", 32'(core), 32'h0);
  endtask

  task automatic wait_load(input int lim, input logic [14:0] exp);
    int k = 0;
    do begin
      @(posedge clock_i);
      k++;
    end while (load !== 1'b1 && k < lim);
    chk("pc_load", 32'(load), 32'h1);
    chk("pc_value", 32'(pcv), 32'(exp));
  endtask

  task automatic sleep_in();
    tick(1);
    slp <= 1'b1;
    tick(1);
    slp <= 1'b0;
    tick(2);
    chk("sleeping", 32'(sleeping), 32'h1);
  endtask

  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  // a hang is cut short long after the sequence should have ended
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end

  // ********
  // sequence
  // ********
  initial begin
    rst_b_i = 1'b0;
    hold = 1'b1;
    {pin_en, por, stk_en} = 3'h7;
    {global_interrupt_enable, oreq} = 2'h3;
    {low_voltage_program_enable, powerup_timer_n, bor, prog, osc} = 5'h0;
    {wclr, slp, iwake, wexp, ovf, unf, rins} = 7'h0;
    {avs_read, avs_write} = 2'h0;
    avs_address = 3'h0;
    avs_writedata = 32'h0;
    tick(2);
    rst_b_i <= 1'b1;
    tick(1);
    chk("flags", 32'(flags), 32'h37);
    rdchk(rss_pkg::ADDR_POWER_CONTROL_REG, 32'h0D, "power_control_reg");
    rdchk(rss_pkg::ADDR_STATUS, 32'h18, "status");
    rdchk(3'h5, 32'h0, "unmapped");
    por <= 1'b0;
    tick(60);
    chk("core_reset", 32'(core), 32'h1);
    osc <= 1'b1;
    tick(10);
    chk("core_reset", 32'(core), 32'h1);
    rdchk(rss_pkg::ADDR_PIN, 32'h6, "pin");
    hold <= 1'b0;
    wait_run(60);
    chk("quick_start", 32'(n <= 35), 32'h1);
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, rss_pkg::ADDR_POWER_CONTROL_REG, 32'hC0);
      powerup_timer_n <= i[0];
      {oreq, osc} <= {2{~i[0]}};
      prog <= 1'b1;
      tick(1);
      prog <= 1'b0;
      wait_run(60);
      chk("powerup_timer_wait", 32'(n >= 20), 32'(i == 0));
      chk("flags", 32'(flags), 32'h37);
    end
    {oreq, osc} <= 2'h3;
    bus(1'b1, rss_pkg::ADDR_POWER_CONTROL_REG, 32'h0C);
    hold <= 1'b1;
    tick(10);
    hold <= 1'b0;
    tick(40);
    chk("core_reset", 32'(core), 32'h0);
    chk("flags", 32'(flags), 32'h33);
    hold <= 1'b1;
    wait_load(40, rss_pkg::PC_RESET);
    tick(2);
    chk("flags", 32'(flags), 32'h13);
    hold <= 1'b0;
    wait_run(60);
    bus(1'b1, rss_pkg::ADDR_CTRL, 32'h1);
    for (int i = 0; i < 4; i++) begin
      {low_voltage_program_enable, pin_en} <= i[1:0];
      tick(4);
      rdchk(rss_pkg::ADDR_PIN, 32'h9 | (32'(i != 0) << 1), "pin");
    end
    {low_voltage_program_enable, pin_en} <= 2'h0;
    bus(1'b1, rss_pkg::ADDR_CTRL, 32'h0);
    tick(2);
    chk("pullup", 32'(pull), 32'h0);
    hold <= 1'b1;
    tick(40);
    chk("core_reset", 32'(core), 32'h0);
    hold <= 1'b0;
    bus(1'b1, rss_pkg::ADDR_CTRL, 32'h1);
    tick(2);
    chk("pullup", 32'(pull), 32'h1);
    // let the filtered pin settle high before the pin function returns
    tick(30);
    pin_en <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      stk_en <= (i != 4);
      bus(1'b1, rss_pkg::ADDR_POWER_CONTROL_REG, 32'h0C);
      wclr <= 1'b1;
      tick(1);
      wclr <= 1'b0;
      {wexp, ovf, unf, rins} <= ev[i];
      tick(1);
      {wexp, ovf, unf, rins} <= 4'h0;
      if (i < 4) wait_load(5, rss_pkg::PC_RESET);
      tick(3);
      chk("flags", 32'(flags), 32'(fl[i]));
      wait_run(30);
    end
    bus(1'b1, rss_pkg::ADDR_POWER_CONTROL_REG, 32'hC2);
    bor <= 1'b1;
    tick(5);
    bor <= 1'b0;
    wait_run(60);
    chk("flags", 32'(flags), 32'h3B);
    sleep_in();
    iwake <= 1'b1;
    tick(1);
    iwake <= 1'b0;
    wait_load(5, 15'h0101);
    tick(1);
    chk("vector", 32'(pcv), 32'(rss_pkg::PC_VECTOR));
    chk("push", 32'(push), 32'h1);
    chk("to_pd", 32'(flags[1:0]), 32'h2);
    sleep_in();
    global_interrupt_enable <= 1'b0;
    iwake <= 1'b1;
    tick(1);
    iwake <= 1'b0;
    wait_load(5, 15'h0101);
    tick(1);
    chk("no_vector", 32'(push | load), 32'h0);
    global_interrupt_enable <= 1'b1;
    sleep_in();
    wexp <= 1'b1;
    tick(1);
    wexp <= 1'b0;
    wait_load(5, 15'h0101);
    tick(1);
    chk("to_pd", 32'(flags[1:0]), 32'h0);
    chk("core_reset", 32'(core), 32'h0);
    sleep_in();
    hold <= 1'b1;
    wait_load(40, rss_pkg::PC_RESET);
    tick(2);
    chk("flags", 32'(flags), 32'h1A);
    hold <= 1'b0;
    wait_run(60);
    chk("pin_oe", 32'(oe), 32'h0);
    chk("pin_drive", 32'(drv), 32'h0);
    conclude();
  end
endmodule
